// file: hw/lta_pkg.sv
package lta_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int OFS_W = 6;           // Low index bits select the register in a channel
  localparam int CH_SHIFT = 6;        // Channel stride of 0x40 register indices

  // ---------------------------------------------------------------
  // Register indices within one channel (byte address is four times)
  // ---------------------------------------------------------------
  localparam logic [OFS_W-1:0] OFS_ERR = 6'h0E;
  localparam logic [OFS_W-1:0] OFS_AIS = 6'h0F;
  localparam logic [OFS_W-1:0] OFS_PG = 6'h10;
  localparam logic [OFS_W-1:0] OFS_PD = 6'h11;
  localparam logic [OFS_W-1:0] OFS_ARBL = 6'h12;
  localparam logic [OFS_W-1:0] OFS_ARBM = 6'h13;
  localparam logic [OFS_W-1:0] OFS_ARBH = 6'h14;
  localparam logic [OFS_W-1:0] OFS_IBL = 6'h15;
  localparam logic [OFS_W-1:0] OFS_IBG = 6'h16;
  localparam logic [OFS_W-1:0] OFS_LOOP = 6'h19;
  localparam logic [OFS_W-1:0] OFS_STAT = 6'h1A;
  localparam logic [IDX_W-1:0] IDX_EVENT = 10'h3F0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AIS_TX_FORCE = 4;
  localparam int AIS_RX_SYS = 3;
  localparam int AIS_RX_LINE = 2;
  localparam int AIS_TX_SYS = 1;
  localparam int AIS_TX_LINE = 0;
  localparam int PG_CLK = 6;
  localparam int PG_PAT_LO = 4;
  localparam int PG_DIR = 3;
  localparam int PG_INV = 2;
  localparam int PD_DIR = 3;
  localparam int PD_INV = 2;
  localparam int SINGLE_ERROR_INSERT = 5;
  localparam int LOOP_REMOTE = 1;
  localparam int IBL_GEN_LO = 4;
  localparam int EVT_VALID = 8;

  // ---------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] AIS_RST = 8'h00;
  localparam logic [7:0] PG_RST = 8'h00;
  localparam logic [7:0] PD_RST = 8'h03;
  localparam logic [7:0] ARB_RST = 8'h55;
  localparam logic [7:0] IBL_RST = 8'h01;
  localparam logic [7:0] LOOP_RST = 8'h00;
  localparam logic [7:0] AIS_MASK = 8'h1F;
  localparam logic [7:0] PG_MASK = 8'h7F;
  localparam logic [7:0] PD_MASK = 8'h0F;
  localparam logic [7:0] IBL_MASK = 8'h3F;
  localparam logic [7:0] LOOP_MASK = 8'h0F;

  // ---------------------------------------------------------------
  // Pattern lengths and encodings
  // ---------------------------------------------------------------
  localparam logic [4:0] USER_TOP = 5'h17;   // 24-bit pattern, bit 23 first
  localparam logic [4:0] IB_MIN_TOP = 5'h04; // Shortest inband code is 5 bits
  localparam logic [1:0] SEQ_QRSS = 2'h0;
  localparam logic [1:0] SEQ_P15 = 2'h1;
  localparam logic [1:0] DET_USER = 2'h3;

  typedef enum logic [1:0] {GEN_OFF, GEN_PRBS, GEN_USER, GEN_INBAND} lta_gen_e;

  // Next sequence bit; all-zero state or a 14-zero QRSS run forces a one
  function automatic logic prbsBit(input logic [19:0] r, input logic [1:0] sel);
    logic fb;
    logic zero;
    fb = 1'b0;
    zero = 1'b0;
    if (sel == SEQ_QRSS) begin
      fb = r[19] ^ r[16];
      zero = (r[13:0] == 14'h0000);
    end else if (sel == SEQ_P15) begin
      fb = r[14] ^ r[13];
      zero = (r[14:0] == 15'h0000);
    end else begin
      fb = r[10] ^ r[8];
      zero = (r[10:0] == 11'h000);
    end
    return fb | zero;
  endfunction

endpackage

// file: hw/lta_line_test.sv
`timescale 1ns/1ns
`default_nettype none

// -----------------------------------------------------------------
// Event FIFO
// -----------------------------------------------------------------
module lta_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,             // System clock
  input wire logic arst_n,               // Async reset, active low
  input wire logic inValid,              // Word offered
  output logic inReady,                  // Room for a word
  input wire logic [WIDTH-1:0] inData,   // Offered word
  output logic outValid,                 // Word available
  input wire logic outReady,             // Word taken
  output logic [WIDTH-1:0] outData       // Oldest word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr, rdPtr;
  logic [PW:0] count;
  logic push, pop;

  // Flags come from the count, so full and empty are exact
  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage has no reset; outValid guards every read
  always_ff @(posedge core_clk) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule // lta_fifo

// -----------------------------------------------------------------
// Top: per-channel alarm insertion, pattern generator and detector
// -----------------------------------------------------------------
module lta_line_test
  import lta_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int SYNC_BITS = 32,
  parameter logic [7:0] IBG_RST = 8'h00,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,                 // 125 MHz system clock
  input wire logic arst_n,                   // Async reset, active low
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB access phase
  input wire logic pwrite,                   // APB direction
  input wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input wire logic [DATA_W-1:0] pwdata,      // APB write data
  output logic [DATA_W-1:0] prdata,          // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error, unmapped address
  input wire logic external_reference_clock, // Shared pattern reference clock
  input wire logic [NUM_CH-1:0] rxClk,       // Recovered receive clocks
  input wire logic [NUM_CH-1:0] txClk,       // Transmit clocks
  input wire logic [NUM_CH-1:0] rxData,      // Receive data from line
  input wire logic [NUM_CH-1:0] txData,      // Transmit data from system
  input wire logic [NUM_CH-1:0] system_signal_loss, // System-side loss
  input wire logic [NUM_CH-1:0] line_signal_loss,   // Line-side loss
  output logic [NUM_CH-1:0] txLineData,      // Data toward the line
  output logic [NUM_CH-1:0] rxSysData        // Data toward the system
);
  localparam int CH_W = $clog2(NUM_CH);
  localparam int SYN_W = 6 * NUM_CH + 1;
  localparam int EVT_W = CH_W + 1;
  localparam int CNT_W = $clog2(SYNC_BITS + 1);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYN_W-1:0] pinRaw, pinMeta, pinSync;
  logic extPrev, extEdge;
  logic [NUM_CH-1:0] rxClkPrev, txClkPrev, rxEdge, txEdge;
  logic [NUM_CH-1:0] rxDataS, txDataS, sysLossS, lineLossS;

  assign pinRaw = {external_reference_clock, rxClk, txClk, rxData, txData,
                   system_signal_loss, line_signal_loss};

  // Two flops before anything reads a pin
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  // Edge detectors look only at the second stage
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      extPrev <= 1'b0;
      rxClkPrev <= '0;
      txClkPrev <= '0;
    end else begin
      extPrev <= pinSync[SYN_W-1];
      rxClkPrev <= pinSync[6*NUM_CH-1 -: NUM_CH];
      txClkPrev <= pinSync[5*NUM_CH-1 -: NUM_CH];
    end
  end

  assign extEdge = pinSync[SYN_W-1] & ~extPrev;
  assign rxEdge = pinSync[6*NUM_CH-1 -: NUM_CH] & ~rxClkPrev;
  assign txEdge = pinSync[5*NUM_CH-1 -: NUM_CH] & ~txClkPrev;
  assign rxDataS = pinSync[4*NUM_CH-1 -: NUM_CH];
  assign txDataS = pinSync[3*NUM_CH-1 -: NUM_CH];
  assign sysLossS = pinSync[2*NUM_CH-1 -: NUM_CH];
  assign lineLossS = pinSync[NUM_CH-1:0];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] idx;
  logic [CH_W-1:0] chSel;
  logic [OFS_W-1:0] ofs;
  logic chanHit, eventHit, addrHit, setupPh, accessDone, wrEn, rdEvent;
  logic [7:0] wByte;
  logic [DATA_W-1:0] rdData;

  // Known per-channel register offsets
  function automatic logic isChanReg(input logic [OFS_W-1:0] o);
    return (o >= OFS_ERR && o <= OFS_IBG) || o == OFS_LOOP || o == OFS_STAT;
  endfunction

  assign idx = paddr[ADDR_W-1:2];
  assign chSel = CH_W'(idx[IDX_W-1:CH_SHIFT]);
  assign ofs = idx[OFS_W-1:0];
  assign chanHit = isChanReg(ofs) &&
                   (32'(idx[IDX_W-1:CH_SHIFT]) < NUM_CH);
  assign eventHit = (idx == IDX_EVENT);
  assign addrHit = chanHit | eventHit;
  assign setupPh = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrEn = accessDone & pwrite & chanHit;
  assign rdEvent = accessDone & ~pwrite & eventHit;
  assign wByte = pwdata[7:0];

  // Answer is prepared in setup so every bus output leaves a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh & ~addrHit;
      if (setupPh) prdata <= pwrite ? '0 : rdData;
    end
  end

  // ---------------------------------------------------------------
  // Control registers, one set per channel
  // ---------------------------------------------------------------
  logic [7:0] aisR [NUM_CH];
  logic [7:0] pgR [NUM_CH];
  logic [7:0] pdR [NUM_CH];
  logic [23:0] arbR [NUM_CH];
  logic [7:0] iblR [NUM_CH];
  logic [7:0] ibgR [NUM_CH];
  logic [7:0] loopR [NUM_CH];
  logic [NUM_CH-1:0] errPend;
  logic [NUM_CH-1:0] syncV;

  // Writes land only on the completing access edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        aisR[i] <= AIS_RST;
        pgR[i] <= PG_RST;
        pdR[i] <= PD_RST;
        arbR[i] <= {ARB_RST, ARB_RST, ARB_RST};
        iblR[i] <= IBL_RST;
        ibgR[i] <= IBG_RST;
        loopR[i] <= LOOP_RST;
      end
    end else if (wrEn) begin
      case (ofs)
        OFS_AIS: aisR[chSel] <= wByte & AIS_MASK;
        OFS_PG: pgR[chSel] <= wByte & PG_MASK;
        OFS_PD: pdR[chSel] <= wByte & PD_MASK;
        OFS_ARBL: arbR[chSel][7:0] <= wByte;
        OFS_ARBM: arbR[chSel][15:8] <= wByte;
        OFS_ARBH: arbR[chSel][23:16] <= wByte;
        OFS_IBL: iblR[chSel] <= wByte & IBL_MASK;
        OFS_IBG: ibgR[chSel] <= wByte;
        OFS_LOOP: loopR[chSel] <= wByte & LOOP_MASK;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Sync-change events toward software
  // ---------------------------------------------------------------
  logic [CH_W-1:0] scanCh;
  logic [NUM_CH-1:0] reported;
  logic evtValid, evtReady, headValid;
  logic [EVT_W-1:0] evtData, headData;

  // A change waits on its channel while the FIFO is full
  assign evtValid = reported[scanCh] != syncV[scanCh];
  assign evtData = {syncV[scanCh], scanCh};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scanCh <= '0;
      reported <= '0;
    end else if (evtValid & evtReady) begin
      reported[scanCh] <= syncV[scanCh];
    end else if (!evtValid) begin
      scanCh <= (32'(scanCh) == NUM_CH - 1) ? '0 : scanCh + 1'b1;
    end
  end

  lta_fifo #(.WIDTH(EVT_W), .DEPTH(FIFO_DEPTH)) u_evt_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inValid(evtValid),
    .inReady(evtReady),
    .inData(evtData),
    .outValid(headValid),
    .outReady(rdEvent),
    .outData(headData)
  );

  // Read selection
  always_comb begin
    rdData = '0;
    if (eventHit) begin
      rdData[EVT_VALID] = headValid;
      rdData[EVT_W-1:0] = headValid ? headData : '0;
    end else if (chanHit) begin
      case (ofs)
        OFS_ERR: rdData[SINGLE_ERROR_INSERT] = errPend[chSel];
        OFS_AIS: rdData[7:0] = aisR[chSel];
        OFS_PG: rdData[7:0] = pgR[chSel];
        OFS_PD: rdData[7:0] = pdR[chSel];
        OFS_ARBL: rdData[7:0] = arbR[chSel][7:0];
        OFS_ARBM: rdData[7:0] = arbR[chSel][15:8];
        OFS_ARBH: rdData[7:0] = arbR[chSel][23:16];
        OFS_IBL: rdData[7:0] = iblR[chSel];
        OFS_IBG: rdData[7:0] = ibgR[chSel];
        OFS_LOOP: rdData[7:0] = loopR[chSel];
        OFS_STAT: rdData[0] = syncV[chSel];
        default: rdData = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-channel datapath
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    lta_gen_e pat;
    logic [1:0] seqSel;
    logic [4:0] ptrTop, ptr;
    logic [19:0] lfsr;
    logic [23:0] detNext, dsr;
    logic [CNT_W-1:0] goodCnt;
    logic genDir, genInv, genTick, genBit, seqBit, flip, pend, errSet;
    logic detTick, detBit, detPred, detUser, matchSeen, sync, transmit_alarm_force, rxAis;

    assign pat = lta_gen_e'(pgR[c][PG_PAT_LO +: 2]);
    assign genDir = pgR[c][PG_DIR];
    assign genInv = pgR[c][PG_INV] & (pat == GEN_PRBS || pat == GEN_USER);
    assign seqSel = pgR[c][1:0];
    // Reference: shared clock at 0, else the path's own clock
    assign genTick = pgR[c][PG_CLK] ? (genDir ? rxEdge[c] : txEdge[c])
                                    : extEdge;
    assign ptrTop = (pat == GEN_USER) ? USER_TOP
                                      : IB_MIN_TOP + 5'(iblR[c][IBL_GEN_LO +: 2]);
    assign seqBit = prbsBit(lfsr, seqSel);
    assign flip = pend & (pat == GEN_PRBS || pat == GEN_USER);

    // Generator steps once per reference edge
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        lfsr <= '0;
        ptr <= USER_TOP;
        genBit <= 1'b0;
      end else if (genTick) begin
        ptr <= (ptr == '0 || ptr > ptrTop) ? ptrTop : ptr - 1'b1;
        case (pat)
          GEN_PRBS: begin
            lfsr <= {lfsr[18:0], seqBit}; // Unflipped bit keeps the sequence
            genBit <= seqBit ^ genInv ^ flip;
          end
          GEN_USER: genBit <= arbR[c][ptr] ^ genInv ^ flip;
          GEN_INBAND: genBit <= ibgR[c][ptr[2:0]];
          default: genBit <= 1'b0;
        endcase
      end
    end

    // Error request arms on a 0-to-1 write; one written while a request is pending is dropped, even in the clearing cycle
    assign errSet = wrEn && ofs == OFS_ERR && 32'(chSel) == c && wByte[SINGLE_ERROR_INSERT] && !pend;
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) pend <= 1'b0;
      else if (errSet) pend <= 1'b1;
      else if (genTick && flip) pend <= 1'b0;
    end
    assign errPend[c] = pend;

    // Detector input: receive path at 0, transmit path at 1
    assign detTick = pdR[c][PD_DIR] ? txEdge[c] : rxEdge[c];
    assign detBit = (pdR[c][PD_DIR] ? txDataS[c] : rxDataS[c]) ^ pdR[c][PD_INV];
    assign detUser = (pdR[c][1:0] == DET_USER);
    assign detPred = detUser ? dsr[23] : prbsBit(dsr[19:0], pdR[c][1:0]);
    assign detNext = {dsr[22:0], detBit};

    // Sync needs SYNC_BITS good bits in a row; one bad bit drops it
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        dsr <= '0;
        goodCnt <= '0;
        matchSeen <= 1'b0;
        sync <= 1'b0;
      end else if (detTick) begin
        dsr <= detNext;
        if (detBit != detPred) begin
          goodCnt <= '0;
          matchSeen <= 1'b0;
          sync <= 1'b0;
        end else begin
          if (32'(goodCnt) < SYNC_BITS) goodCnt <= goodCnt + 1'b1;
          if (detNext == arbR[c]) matchSeen <= 1'b1;
          sync <= (32'(goodCnt) >= SYNC_BITS - 1) && (!detUser || matchSeen);
        end
      end
    end
    assign syncV[c] = sync;

    // Alarm all-ones has priority over generated and normal data
    assign transmit_alarm_force = (aisR[c][AIS_TX_FORCE] & ~loopR[c][LOOP_REMOTE])
                 | (aisR[c][AIS_TX_SYS] & sysLossS[c])
                 | (aisR[c][AIS_TX_LINE] & lineLossS[c]);
    assign rxAis = (aisR[c][AIS_RX_SYS] & sysLossS[c])
                 | (aisR[c][AIS_RX_LINE] & lineLossS[c]);

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        txLineData[c] <= 1'b0;
        rxSysData[c] <= 1'b0;
      end else begin
        txLineData[c] <= transmit_alarm_force | ((pat != GEN_OFF && !genDir) ? genBit : txDataS[c]);
        rxSysData[c] <= rxAis | ((pat != GEN_OFF && genDir) ? genBit : rxDataS[c]);
      end
    end
  end
endmodule // lta_line_test

`default_nettype wire

// file: verif/lta_line_test_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ------------
// Port checker
// ------------
module lta_line_test_monitor
  import lta_pkg::*;
#(
  parameter int NUM_CH = 16
) (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [DATA_W-1:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [NUM_CH-1:0] system_signal_loss, // System loss
  input wire logic [NUM_CH-1:0] line_signal_loss, // Line loss
  input wire logic [NUM_CH-1:0] txLineData, // To line
  input wire logic [NUM_CH-1:0] rxSysData // To system
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] ais;
  logic loopRemote;
  wire logic commit;
  // A write lands only on a completed, accepted access
  assign commit = psel && penable && pready && pwrite && !pslverr;
  // Channel 0 shadow, so alarm checks know which enables are live
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ais <= 8'h00;
      loopRemote <= 1'b0;
    end else if (commit && paddr == {4'h0, OFS_AIS, 2'b00}) begin
      ais <= pwdata[7:0] & AIS_MASK;
    end else if (commit && paddr == {4'h0, OFS_LOOP, 2'b00}) begin
      loopRemote <= pwdata[LOOP_REMOTE];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  // Loss must last through two sync flops and the output flop
  sequence s_loss(en, loss);
    (en && loss)[*4];
  endsequence
  property p_rdy;
    s_setup |=> pready;
  endproperty
  property p_one;
    pready |=> !pready;
  endproperty
  property p_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  property p_err;
    pslverr |-> pready && psel && penable;
  endproperty
  property p_force;
    (ais[AIS_TX_FORCE] && !loopRemote)[*2] |-> txLineData[0];
  endproperty
  property p_txl;
    s_loss(ais[AIS_TX_LINE], line_signal_loss[0]) |-> txLineData[0];
  endproperty
  property p_txs;
    s_loss(ais[AIS_TX_SYS], system_signal_loss[0]) |-> txLineData[0];
  endproperty
  property p_rxl;
    s_loss(ais[AIS_RX_LINE], line_signal_loss[0]) |-> rxSysData[0];
  endproperty
  property p_rxs;
    s_loss(ais[AIS_RX_SYS], system_signal_loss[0]) |-> rxSysData[0];
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("no ready after setup");
  a_one: assert property (p_one)
    else $error("ready longer than one cycle");
  a_cause: assert property (p_cause)
    else $error("ready without setup");
  a_err: assert property (p_err)
    else $error("error outside access");
  a_force: assert property (p_force)
    else $error("forced alarm missing");
  a_txl: assert property (p_txl)
    else $error("tx line loss alarm missing");
  a_txs: assert property (p_txs)
    else $error("tx system loss alarm missing");
  a_rxl: assert property (p_rxl)
    else $error("rx line loss alarm missing");
  a_rxs: assert property (p_rxs)
    else $error("rx system loss alarm missing");
endmodule // lta_line_test_monitor
`default_nettype wire

// file: verif/lta_far_end.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------
// Line and framer paths
// ---------------------
module lta_far_end #(
  parameter int NUM_CH = 16
) (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Reset
  output logic [NUM_CH-1:0] rxClk, // Recovered clocks
  output logic [NUM_CH-1:0] txClk, // Transmit clocks
  output logic [NUM_CH-1:0] rxData, // Line data
  output logic [NUM_CH-1:0] txData // System data
);
  logic [3:0] div;
  // Slow clocks stay far under the pin sampling limit
  assign rxClk = {NUM_CH{div[3]}};
  assign txClk = {NUM_CH{div[2]}};
  // Data flips every cycle, so a path not forced to ones always shows a zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 4'h0;
      rxData <= '0;
      txData <= '1;
    end else begin
      div <= div + 4'h1;
      rxData <= ~rxData;
      txData <= ~txData;
    end
  end
endmodule // lta_far_end
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ---------
// Testbench
// ---------
module testbench
  import lta_pkg::*;
;
  logic core_clk;
  logic arst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic extClk;
  logic [15:0] rxClk;
  logic [15:0] txClk;
  logic [15:0] rxData;
  logic [15:0] txData;
  logic [15:0] sysLoss;
  logic [15:0] lineLoss;
  logic [15:0] txLineData;
  logic [15:0] rxSysData;
  logic [DATA_W-1:0] q;
  logic e;
  logic r;
  logic [23:0] pat = 24'hA5C3F0;
  logic [7:0] pgv [3] = '{8'h20, 8'h24, 8'h28};
  int errors;
  int cmp_count;
  lta_line_test #(
    .SYNC_BITS(8)
  ) u_lta_line_test (
    .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .external_reference_clock(extClk), .rxClk, .txClk, .rxData, .txData,
    .system_signal_loss(sysLoss), .line_signal_loss(lineLoss), .txLineData, .rxSysData
  );
  lta_far_end u_lta_far_end (
    .core_clk, .arst_n, .rxClk, .txClk, .rxData, .txData
  );
  // 125 MHz clock
  always #4 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [11:0] ad(input logic [3:0] ch, input logic [5:0] o);
    return {ch, o, 2'b00};
  endfunction
  // One APB transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 8'h00);
    check(q, {24'h0, x});
    check({31'h0, e}, {31'h0, xe});
  endtask
  // Channel 0 path: all ones over 8 cycles, against a toggling source
  task automatic allOnes(input logic tx, input logic exp);
    repeat (5) @(posedge core_clk);
    r = 1'b1;
    repeat (8) begin
      @(posedge core_clk);
      r = r & (tx ? txLineData[0] : rxSysData[0]);
    end
    check({31'h0, r}, {31'h0, exp});
  endtask
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, extClk} = 4'h0;
    paddr = '0;
    pwdata = '0;
    sysLoss = '0;
    lineLoss = '0;
    errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset values, masks, channel stride and an unmapped place
    for (int c = 0; c < 16; c += 15) begin
      rd(ad(4'(c), OFS_AIS), 8'h00, 1'b0);
      rd(ad(4'(c), OFS_PG), 8'h00, 1'b0);
      rd(ad(4'(c), OFS_PD), 8'h03, 1'b0);
    end
    apb(1'b1, ad(4'hF, OFS_PD), 8'hFF);
    rd(ad(4'hF, OFS_PD), 8'h0F, 1'b0);
    apb(1'b1, ad(4'h1, OFS_AIS), 8'h1F);
    rd(ad(4'h0, OFS_AIS), 8'h00, 1'b0);
    rd(ad(4'h1, OFS_AIS), 8'h1F, 1'b0);
    rd(ad(4'h0, 6'h00), 8'h00, 1'b1);
    // Forced alarm, then remote loopback overrides it
    apb(1'b1, ad(4'h0, OFS_AIS), 8'h10);
    allOnes(1'b1, 1'b1);
    apb(1'b1, ad(4'h0, OFS_LOOP), 8'h02);
    allOnes(1'b1, 1'b0);
    apb(1'b1, ad(4'h0, OFS_LOOP), 8'h00);
    // Each automatic enable with its own loss; the other path stays clean
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ad(4'h0, OFS_AIS), 8'(1 << i));
      lineLoss[0] <= (i % 2 == 0);
      sysLoss[0] <= (i % 2 == 1);
      allOnes(i < 2, 1'b1);
      allOnes(i >= 2, 1'b0);
      lineLoss[0] <= 1'b0;
      sysLoss[0] <= 1'b0;
    end
    // User pattern, bit 23 first: plain, inverted, toward the system
    apb(1'b1, ad(4'h3, OFS_ARBH), 8'hA5);
    apb(1'b1, ad(4'h3, OFS_ARBM), 8'hC3);
    apb(1'b1, ad(4'h3, OFS_ARBL), 8'hF0);
    foreach (pgv[k]) begin
      apb(1'b1, ad(4'h3, OFS_PG), 8'h00);
      apb(1'b1, ad(4'h3, OFS_PG), pgv[k]);
      for (int b = 23; b >= 0; b--) begin
        extClk <= 1'b1;
        repeat (6) @(posedge core_clk);
        r = pgv[k][PG_DIR] ? rxSysData[3] : txLineData[3];
        check({31'h0, r}, {31'h0, pat[b] ^ pgv[k][PG_INV]});
        extClk <= 1'b0;
        repeat (10) @(posedge core_clk);
      end
    end
    // Error insert flips only the next user bit, then reads back clear
    apb(1'b1, ad(4'h3, OFS_ERR), 8'h20);
    rd(ad(4'h3, OFS_ERR), 8'h20, 1'b0);
    for (int b = 23; b >= 22; b--) begin
      extClk <= 1'b1;
      repeat (6) @(posedge core_clk);
      check({31'h0, rxSysData[3]}, {31'h0, pat[b] ^ (b == 23)});
      extClk <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
    rd(ad(4'h3, OFS_ERR), 8'h00, 1'b0);
    results();
  end
endmodule // testbench
bind lta_line_test lta_line_test_monitor #(
  .NUM_CH(NUM_CH)
) u_lta_line_test_monitor (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .system_signal_loss, .line_signal_loss, .txLineData, .rxSysData
);
`default_nettype wire
